// ===== osc_trim_defs.vh
// register offsets, field positions, reset values and timing counts
// for the oscillator trim and spread-spectrum block; no logic
`ifndef OSC_TRIM_DEFS_VH
`define OSC_TRIM_DEFS_VH
// register indices (byte address is four times the index)
`define IDX_COARSE_TRIM_SPREAD 16'hA001
`define IDX_FINE_TRIM 16'hA002
`define IDX_OSC_CTRL 16'hA003
`define IDX_OSC_STATUS 16'hA004
// field positions inside the coarse/spread register
`define COARSE_LSB 0
`define COARSE_MSB 1
`define AMP_LSB 2
`define AMP_MSB 3
`define INTERVAL_LSB 4
`define INTERVAL_MSB 7
// control register fields
`define CTRL_STOP_BIT 0
`define CTRL_SYSCLK_SLOW_BIT 1
`define CTRL_WAKE_SLOW_BIT 2
// reset values
`define RST_COARSE_TRIM_SPREAD 8'h02
`define RST_FINE_TRIM 8'h8E
`define RST_OSC_CTRL 8'h00
// amplitude spans per code
`define AMP_SPAN_0 7'h04
`define AMP_SPAN_1 7'h08
`define AMP_SPAN_2 7'h10
`define AMP_SPAN_3 7'h20
// oscillator settling time in oscillator cycles
`define SETTLE_CYCLES 4'hA
`define TRIM_MAX 10'h0FF
`endif

// ===== sync_bit.v
// two flip-flop synchroniser for one level
// assumes clk is the destination clock and reset is synchronous
`timescale 1ns/1ps
module sync_bit (
  input wire clk,
  input wire reset,
  input wire din,
  output reg dout
);
  reg stage1;
  always @(posedge clk) begin
    if (reset) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // sync_bit

// ===== sweep_gen.v
// triangle sweep generator for the spread-spectrum offset
// assumes one tick per oscillator cycle from the caller
`timescale 1ns/1ps
`include "osc_trim_defs.vh"
module sweep_gen (
  input wire clk,
  input wire reset,
  input wire tick,
  input wire [3:0] interval,
  input wire [6:0] span,
  output reg signed [7:0] offset,
  output reg updatePulse
);
  reg [3:0] divCount;
  reg goingUp;
  wire signed [7:0] spanS = {1'b0, span};
  always @(posedge clk) begin
    if (reset || interval == 4'h0) begin
      divCount <= 4'h0;
      offset <= 8'sh00;
      goingUp <= 1'b1;
      updatePulse <= 1'b0;
    end else begin
      updatePulse <= 1'b0;
      if (tick) begin
        if (divCount >= interval - 4'h1) begin // R08
          divCount <= 4'h0;
          updatePulse <= 1'b1;
          // R14 step by one, reverse at each extreme
          if (goingUp) begin
            if (offset >= spanS) begin
              goingUp <= 1'b0;
              offset <= offset - 8'sh01;
            end else begin
              offset <= offset + 8'sh01;
            end
          end else begin
            if (offset <= -spanS) begin
              goingUp <= 1'b1;
              offset <= offset + 8'sh01;
            end else begin
              offset <= offset - 8'sh01;
            end
          end
          // clamp if the span shrank mid-sweep
          if (offset > spanS) begin
            offset <= spanS;
          end else if (offset < -spanS) begin
            offset <= -spanS;
          end
        end else begin
          divCount <= divCount + 4'h1;
        end
      end
    end
  end
endmodule // sweep_gen

// ===== osc_trim_spread_spectrum.v
// oscillator trim registers, spread-spectrum sweep and enable control
// assumes an APB master on clk; oscillator cycles arrive as a pin level
//
// What this block does
// (R01) fast oscillator is default clock after reset
// (R02) glitch-free enable, settle about ten cycles
// (R03) fast oscillator off only in stop mode or while the control register stop bit is set
// (R04) reset restores both trim registers; software reloads
// (R05) zero interval passes fine trim unchanged
// (R06) nonzero interval adds offset within amplitude
// (R07) amplitude code selects span 4,8,16,32
// (R08) interval counts oscillator cycles per update
// (R09) full sweep is 4*interval*span cycles, span 4 << amp
// (R10) effective code saturates at 0 and 255
// (R11) software keeps fine trim inside amplitude margins
// (R12) software calibrates by binary search on fine
// (R13) slow oscillator always runs, selectable as clock
// (R14) offset steps by one as a triangle
`timescale 1ns/1ps
`include "osc_trim_defs.vh"
module osc_trim_spread_spectrum (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire oscCycle,
  input wire stopMode,
  output reg fastOscEnable,
  output reg fastOscReady,
  output reg [1:0] coarseTrim,
  output reg [7:0] effectiveTrimCode,
  output reg sysClkSelSlow,
  output reg wakeTimerClkSlow,
  output reg slowOscEnable
);
  ////////////////////////////////////////////////////////////////////////
  // apb decode
  reg [7:0] coarseTrimSpread;
  reg [7:0] fineTrim;
  reg [7:0] oscCtrl;
  wire [29:0] wordIdx = paddr[31:2];
  wire hitCoarse = wordIdx == {14'h0000, `IDX_COARSE_TRIM_SPREAD};
  wire hitFine = wordIdx == {14'h0000, `IDX_FINE_TRIM};
  wire hitCtrl = wordIdx == {14'h0000, `IDX_OSC_CTRL};
  wire hitStatus = wordIdx == {14'h0000, `IDX_OSC_STATUS};
  wire hitAny = hitCoarse | hitFine | hitCtrl | hitStatus;
  wire access = psel & penable;
  wire wrEn = access & pwrite;
  assign pready = 1'b1;
  assign pslverr = access & ~hitAny;

  ////////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge clk) begin
    if (reset) begin
      coarseTrimSpread <= `RST_COARSE_TRIM_SPREAD; // R04
      fineTrim <= `RST_FINE_TRIM; // R04
      oscCtrl <= `RST_OSC_CTRL;
    end else if (wrEn) begin
      if (hitCoarse) begin
        coarseTrimSpread <= pwdata[7:0];
      end
      if (hitFine) begin
        fineTrim <= pwdata[7:0];
      end
      if (hitCtrl) begin
        oscCtrl <= {5'h00, pwdata[2:0]};
      end
    end
  end

  wire [3:0] interval = coarseTrimSpread[`INTERVAL_MSB:`INTERVAL_LSB];
  wire [1:0] ampCode = coarseTrimSpread[`AMP_MSB:`AMP_LSB];
  reg [6:0] span;
  always @* begin
    case (ampCode) // R07
      2'b00: span = `AMP_SPAN_0;
      2'b01: span = `AMP_SPAN_1;
      2'b10: span = `AMP_SPAN_2;
      2'b11: span = `AMP_SPAN_3;
      default: span = `AMP_SPAN_0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator cycle detection and power control
  wire oscSync;
  wire stopSync;
  reg oscSyncLast;
  sync_bit u_sync_osc (
    .clk(clk),
    .reset(reset),
    .din(oscCycle),
    .dout(oscSync)
  );
  sync_bit u_sync_stop (
    .clk(clk),
    .reset(reset),
    .din(stopMode),
    .dout(stopSync)
  );
  wire oscTick = oscSync & ~oscSyncLast & fastOscReady;

  wire stopReq = stopSync | oscCtrl[`CTRL_STOP_BIT];
  reg [3:0] settleCount;
  always @(posedge clk) begin
    if (reset) begin
      oscSyncLast <= 1'b0;
      fastOscEnable <= 1'b1; // R01
      fastOscReady <= 1'b0;
      settleCount <= 4'h0;
      slowOscEnable <= 1'b1;
      sysClkSelSlow <= 1'b0;
      wakeTimerClkSlow <= 1'b0;
    end else begin
      oscSyncLast <= oscSync;
      slowOscEnable <= 1'b1; // R13
      sysClkSelSlow <= oscCtrl[`CTRL_SYSCLK_SLOW_BIT]; // R13
      wakeTimerClkSlow <= oscCtrl[`CTRL_WAKE_SLOW_BIT]; // R13
      // enable is a registered level: a single clean edge per change
      fastOscEnable <= ~stopReq; // R03 R02
      if (!fastOscEnable || stopReq) begin
        fastOscReady <= 1'b0;
        settleCount <= 4'h0;
      end else if (!fastOscReady) begin
        if (oscSync & ~oscSyncLast) begin
          if (settleCount == `SETTLE_CYCLES - 4'h1) begin // R02
            fastOscReady <= 1'b1;
          end else begin
            settleCount <= settleCount + 4'h1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sweep and saturation
  wire signed [7:0] offset;
  wire updatePulse;
  sweep_gen u_sweep (
    .clk(clk),
    .reset(reset),
    .tick(oscTick),
    .interval(interval),
    .span(span),
    .offset(offset),
    .updatePulse(updatePulse)
  );
  // R09 triangle of 4*span steps, each interval cycles long

  wire signed [9:0] sum = $signed({2'b00, fineTrim}) +
    $signed({{2{offset[7]}}, offset});
  reg [7:0] next_code;
  always @* begin
    if (interval == 4'h0) begin
      next_code = fineTrim; // R05
    end else if (sum < 10'sd0) begin
      next_code = 8'h00; // R10
    end else if (sum > $signed(`TRIM_MAX)) begin
      next_code = 8'hFF; // R10
    end else begin
      next_code = sum[7:0]; // R06
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      effectiveTrimCode <= `RST_FINE_TRIM;
      coarseTrim <= 2'b10;
    end else begin
      effectiveTrimCode <= next_code;
      coarseTrim <= coarseTrimSpread[`COARSE_MSB:`COARSE_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data
  always @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      if (hitCoarse) begin
        prdata <= {24'h000000, coarseTrimSpread};
      end else if (hitFine) begin
        prdata <= {24'h000000, fineTrim};
      end else if (hitCtrl) begin
        prdata <= {24'h000000, oscCtrl};
      end else if (hitStatus) begin
        prdata <= {22'h000000 & 22'h3FFFFF, fastOscEnable, fastOscReady,
          effectiveTrimCode};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule // osc_trim_spread_spectrum

// ===== osc_model.sv
// behavioural model of the analog fast oscillator
// assumes the enable comes from the trim block; period 300 ns
`timescale 1ns/1ps
module osc_model (
  input wire enable,
  output reg oscCycle
);
  // stops at its level while disabled, so no extra edge appears;
  // offset so that no toggle falls on a clock edge
  initial begin
    oscCycle = 1'b0;
    #7;
    forever begin
      #150;
      if (enable) oscCycle = !oscCycle;
    end
  end
endmodule // osc_model

// ===== osc_trim_props.sv
// assertions on the oscillator trim block ports
// bound into the top module; sees its ports only
`timescale 1ns/1ps
`include "osc_trim_defs.vh"
module osc_trim_props (
  input wire clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  input wire stopMode,
  input wire fastOscEnable,
  input wire fastOscReady,
  input wire [7:0] effectiveTrimCode,
  input wire slowOscEnable
);
  reg [7:0] cs;
  reg [7:0] fine;
  reg [3:0] pi;
  reg [9:0] pf;
  reg [9:0] ps;
  wire acc = psel && penable;
  wire [29:0] idx = paddr[31:2];
  wire [9:0] e = {2'h0, effectiveTrimCode};
  wire mapped = idx >= 30'h0A001 && idx <= 30'h0A004;
  // shadow of the trim registers taken from bus writes
  always @(posedge clk) begin
    if (reset) begin
      cs <= `RST_COARSE_TRIM_SPREAD;
      fine <= `RST_FINE_TRIM;
    end else if (acc && pwrite && idx == 30'h0A001) begin
      cs <= pwdata[7:0];
    end else if (acc && pwrite && idx == 30'h0A002) begin
      fine <= pwdata[7:0];
    end
    pi <= cs[7:4];
    pf <= {2'h0, fine};
    ps <= 10'h004 << cs[3:2];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  boot_on_a: assert property (disable iff (1'b0) reset |=> fastOscEnable)
    else $error("fast oscillator off after reset");
  reset_code_a: assert property (disable iff (1'b0)
    reset |=> effectiveTrimCode == `RST_FINE_TRIM)
    else $error("trim code not default after reset");
  code_fixed_a: assert property ((pi == 4'h0)[*3] |-> e == pf)
    else $error("fixed trim code differs from fine trim");
  code_span_a: assert property ((pi != 4'h0)[*3] |->
    e + ps >= pf && e <= pf + ps)
    else $error("swept code outside amplitude");
  stop_off_a: assert property (stopMode[*4] |-> !fastOscEnable)
    else $error("oscillator on in stop mode");
  ready_off_a: assert property (!fastOscEnable |-> !fastOscReady)
    else $error("ready while oscillator off");
  settle_a: assert property ($rose(fastOscEnable) |-> !fastOscReady[*8])
    else $error("ready too soon after enable");
  slow_on_a: assert property (slowOscEnable)
    else $error("slow oscillator disabled");
  unmapped_a: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == !mapped)
    else $error("slave error wrong for address");
endmodule // osc_trim_props
bind osc_trim_spread_spectrum osc_trim_props props (.clk, .reset, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pslverr, .stopMode, .fastOscEnable,
  .fastOscReady, .effectiveTrimCode, .slowOscEnable);

// ===== test_osc_trim_spread_spectrum.sv
// testbench for the oscillator trim and spread-spectrum block
// assumes osc_model on the oscillator side, APB master here
`timescale 1ns/1ps
`include "osc_trim_defs.vh"
module test_osc_trim_spread_spectrum;
  localparam [31:0] CS = {14'h0, `IDX_COARSE_TRIM_SPREAD, 2'h0};
  localparam [31:0] FI = {14'h0, `IDX_FINE_TRIM, 2'h0};
  localparam [31:0] CT = {14'h0, `IDX_OSC_CTRL, 2'h0};
  localparam [31:0] ST = {14'h0, `IDX_OSC_STATUS, 2'h0};
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] paddr = 32'h00000000;
  reg [31:0] pwdata = 32'h00000000;
  reg stopMode = 1'b0;
  reg [31:0] rd;
  reg se;
  integer err_count = 0;
  integer checks_done = 0;
  integer k;
  wire pready, pslverr, oscCycle, fastOscEnable, fastOscReady;
  wire sysClkSelSlow, wakeTimerClkSlow, slowOscEnable;
  wire [31:0] prdata;
  wire [1:0] coarseTrim;
  wire [7:0] effectiveTrimCode;
  always #50 clk = ~clk;
  osc_trim_spread_spectrum dut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .oscCycle(oscCycle), .stopMode(stopMode),
    .fastOscEnable(fastOscEnable), .fastOscReady(fastOscReady),
    .coarseTrim(coarseTrim), .effectiveTrimCode(effectiveTrimCode),
    .sysClkSelSlow(sysClkSelSlow), .wakeTimerClkSlow(wakeTimerClkSlow),
    .slowOscEnable(slowOscEnable));
  osc_model osc (.enable(fastOscEnable), .oscCycle(oscCycle));
  task finish_test;
    begin
      if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp, input [8*8:1] nm);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input [31:0] a, input w, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task settle(input integer n);
    begin
      repeat (n) @(posedge clk);
      @(negedge clk);
    end
  endtask
  // samples the swept code once a cycle: span, steps and period
  task sweep(input [7:0] f, input [1:0] am, input [3:0] iv);
    integer i, n, t0, per, c, p, hi, lo, mx, mn, bad;
    begin
      hi = f + (4 << am) > 255 ? 255 : f + (4 << am);
      lo = f - (4 << am);
      apb(CS, 1'b1, 32'h0);
      apb(FI, 1'b1, {24'h0, f});
      apb(CS, 1'b1, {24'h0, iv, am, 2'h1});
      p = f; mx = f; mn = f; bad = 0; n = 0; t0 = 0; per = 0;
      for (i = 0; i < 4000; i = i + 1) begin
        @(negedge clk);
        c = effectiveTrimCode;
        if (c - p > 1 || p - c > 1) bad = 1;
        if (c == hi && p != hi) begin
          n = n + 1;
          if (n == 1) t0 = i;
          if (n == 2) per = i - t0;
        end
        if (c > mx) mx = c;
        if (c < mn) mn = c;
        p = c;
      end
      chk(mx, hi, "max");
      chk(mn, lo, "min");
      chk(bad, 0, "step");
      chk(per, 12 * (4 << am) * iv, "period");
    end
  endtask
  initial begin
    #5000000;
    err_count = err_count + 1;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    apb(CS, 1'b0, 0); chk(rd, 32'h02, "coarse");
    apb(FI, 1'b0, 0); chk(rd, 32'h8E, "fine");
    apb(ST, 1'b0, 0); chk(rd[9], 1, "enable");
    chk(slowOscEnable, 1, "slow");
    for (k = 0; k < 200 && fastOscReady !== 1'b1; k = k + 1) settle(1);
    chk(fastOscReady, 1, "ready");
    apb(FI, 1'b1, 32'h5A);
    apb(CS, 1'b1, 32'h03);
    settle(3);
    chk(coarseTrim, 3, "coarse");
    chk(effectiveTrimCode, 32'h5A, "code");
    apb(CS, 1'b1, 32'h01); apb(FI, 1'b1, 32'h00); settle(2);
    chk(effectiveTrimCode, 32'h00, "cal00");
    apb(FI, 1'b1, 32'hFF); settle(2);
    chk(effectiveTrimCode, 32'hFF, "calFF");
    apb(FI, 1'b1, 32'h7F); settle(2);
    chk(effectiveTrimCode, 32'h7F, "cal7F");
    apb(32'h00028020, 1'b0, 0); chk(se, 1, "slverr");
    chk(rd, 0, "unmapped");
    for (k = 0; k < 4; k = k + 1) sweep(8'h80, k, k + 1);
    sweep(8'hFE, 2'h3, 4'h1);
    apb(CT, 1'b1, 32'h06); settle(2);
    chk({sysClkSelSlow, wakeTimerClkSlow}, 3, "clksel");
    apb(CT, 1'b1, 32'h01); settle(2);
    chk(fastOscEnable, 0, "swstop");
    apb(CT, 1'b1, 32'h00);
    @(posedge clk);
    stopMode <= 1'b1;
    settle(5); chk(fastOscEnable, 0, "stop");
    @(posedge clk);
    stopMode <= 1'b0;
    settle(5); chk(fastOscEnable, 1, "run");
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    apb(CS, 1'b0, 0); chk(rd, 32'h02, "coarse");
    apb(FI, 1'b0, 0); chk(rd, 32'h8E, "fine");
    finish_test;
  end
endmodule // test_osc_trim_spread_spectrum
